//--- sbrsf_pkg.sv
// Operation
// - Prescale field bits 6:4, clocked by bus clock, divides by one to eight.
// - Rate field bits 2:0 divides by two up to 256, giving bit clock.
// - Prescaler output steps the power-of-two divider; bus clock drives prescaler only.
// - Bit-rate register reads and writes are accepted at any time.
// - Status bits 6,3,2,1,0 read zero; status writes change nothing.
// - Receive-full flag, status bit 7, sets when a transfer completes.
// - Receive-full clears after status read with flag set, then data read.
// - Transmit-empty flag, bit 5, high while buffer has room; cleared by read-write.
// - Data write ignored unless status was read earlier with transmit-empty set.
// - Interrupt requested while transmit-empty and transmit interrupt enable are set.
// - Transmit-empty sets whenever a byte moves from buffer into shifter.
// - Idle unit moves written byte to shifter and sets flag within two cycles.
// - On shift completion a queued byte moves and flag sets; else nothing moves.
// - Mode-fault flag, bit 4, sets when master and slave-select input is low.
// - Mode fault detected only with master, fault enable set, select output off.
// - Mode-fault clears after status read as one, then control register one write.
// - Interrupt while receive-full or mode-fault set and receive/fault enable is one.
package sbrsf_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    localparam logic [2:0] OFS_BIT_RATE = 3'h0;
    localparam logic [2:0] OFS_STATUS   = 3'h1;
    localparam logic [2:0] OFS_CTRL_ONE = 3'h2;
    localparam logic [2:0] OFS_CTRL_TWO = 3'h3;
    localparam logic [2:0] OFS_DATA     = 3'h4;
    localparam logic [2:0] OFS_EVT_STS  = 3'h5;
    localparam logic [2:0] OFS_EVT_MASK = 3'h6;

    localparam int unsigned PRE_LSB  = 4;
    localparam int unsigned RATE_LSB = 0;
    localparam logic [7:0]  BIT_RATE_MASK = 8'h77;

    localparam int unsigned STS_RX_FULL  = 7;
    localparam int unsigned STS_TX_EMPTY = 5;
    localparam int unsigned STS_M_FAULT  = 4;

    localparam int unsigned C1_RX_FAULT_IRQ_EN = 7;
    localparam int unsigned C1_TX_IRQ_EN       = 5;
    localparam int unsigned C1_MASTER_SELECT   = 4;
    localparam int unsigned C1_SELECT_OUT_EN   = 1;
    localparam int unsigned C2_FAULT_DETECT_EN = 4;
    localparam logic [7:0]  CTRL_TWO_MASK      = 8'h1b;

    localparam int unsigned EVT_XFER_DONE = 0;
    localparam int unsigned EVT_M_FAULT   = 1;
    localparam int unsigned EVT_TX_LOAD   = 2;
    localparam int unsigned EVT_W         = 3;

    localparam logic [7:0] RST_BIT_RATE = 8'h00;
    localparam logic [7:0] RST_CTRL_ONE = 8'h04;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [2:0] RST_EVT_MASK = 3'h0;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sbrsf_byte_t;

endpackage

//--- sbrsf_core.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module sbrsf_core (
    // Clock and reset.
    input  wire logic                 clk_in,
    input  wire logic                 arst_n_in,
    // Register port.
    input  wire logic [2:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [7:0]           rdata_out,
    // Shifter side.
    input  wire sbrsf_pkg::sbrsf_byte_t rx_done_in,
    output sbrsf_pkg::sbrsf_byte_t    load_out,
    output logic      [7:0]           ctrl_one_out,
    output logic      [7:0]           ctrl_two_out,
    // Serial clock and pins.
    input  wire logic                 ss_n_in,
    output logic                      bit_clk_out,
    output logic                      bit_tick_out,
    // Interrupt.
    output logic                      irq_out
);

    typedef struct packed {
        logic [1:0]                  rst_pipe;
        logic [2:0]                  ss_pipe;
        logic                        ss_n;
        logic [7:0]                  bit_rate;
        logic [7:0]                  ctrl_one;
        logic [7:0]                  ctrl_two;
        logic [2:0]                  pre_cnt;
        logic [7:0]                  div_cnt;
        logic                        bit_clk;
        logic                        bit_tick;
        logic                        rx_full;
        logic                        tx_empty;
        logic                        m_fault;
        logic                        rx_arm;
        logic                        tx_arm;
        logic                        mf_arm;
        logic                        buf_full;
        logic [7:0]                  tx_buf;
        logic                        shift_busy;
        sbrsf_pkg::sbrsf_byte_t      load;
        logic [7:0]                  rx_buf;
        logic [sbrsf_pkg::EVT_W-1:0] evt_sts;
        logic [sbrsf_pkg::EVT_W-1:0] evt_mask;
        logic [7:0]                  rdata;
    } sbrsf_state_t;

    sbrsf_state_t st_ff;
    sbrsf_state_t nxt_st;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [7:0] status_word(input sbrsf_state_t s);
        status_word = 8'h00;
        status_word[sbrsf_pkg::STS_RX_FULL]  = s.rx_full;
        status_word[sbrsf_pkg::STS_TX_EMPTY] = s.tx_empty;
        status_word[sbrsf_pkg::STS_M_FAULT]  = s.m_fault;
    endfunction

    logic       wr_rate;
    logic       wr_ctrl_one;
    logic       wr_ctrl_two;
    logic       wr_data;
    logic       wr_evt_sts;
    logic       wr_evt_mask;
    logic       rd_status;
    logic       rd_data;
    logic [2:0] pre_sel;
    logic [2:0] rate_sel;
    logic       pre_tick;
    logic [7:0] div_inc;
    logic       fault_armed;
    logic       fault_set;
    logic       tx_accept;
    logic       do_load;
    logic       buf_after;
    logic [7:0] byte_after;
    logic [2:0] evt_set;
    logic [7:0] rd_word;

    logic       rx_clear;
    logic       mf_clear;
    logic       tx_req;
    logic       rx_fault_req;
    logic       evt_req;

    always_comb begin
        nxt_st = st_ff;
        wr_rate     = wr_in && hit(addr_in, sbrsf_pkg::OFS_BIT_RATE);
        wr_ctrl_one = wr_in && hit(addr_in, sbrsf_pkg::OFS_CTRL_ONE);
        wr_ctrl_two = wr_in && hit(addr_in, sbrsf_pkg::OFS_CTRL_TWO);
        wr_data     = wr_in && hit(addr_in, sbrsf_pkg::OFS_DATA);
        wr_evt_sts  = wr_in && hit(addr_in, sbrsf_pkg::OFS_EVT_STS);
        wr_evt_mask = wr_in && hit(addr_in, sbrsf_pkg::OFS_EVT_MASK);
        rd_status   = rd_in && hit(addr_in, sbrsf_pkg::OFS_STATUS);
        rd_data     = rd_in && hit(addr_in, sbrsf_pkg::OFS_DATA);

        // Reset release pipe: two stages before the logic leaves reset.
        nxt_st.rst_pipe = {st_ff.rst_pipe[0], 1'b1};

        // Slave-select input: three stages, change taken when last two agree.
        nxt_st.ss_pipe = {st_ff.ss_pipe[1:0], ss_n_in};
        if (st_ff.ss_pipe[2] == st_ff.ss_pipe[1]) begin
            nxt_st.ss_n = st_ff.ss_pipe[2];
        end

        if (wr_rate) begin
            nxt_st.bit_rate = wdata_in & sbrsf_pkg::BIT_RATE_MASK;
        end
        if (wr_ctrl_one) begin
            nxt_st.ctrl_one = wdata_in;
        end
        if (wr_ctrl_two) begin
            nxt_st.ctrl_two = wdata_in & sbrsf_pkg::CTRL_TWO_MASK;
        end
        if (wr_evt_mask) begin
            nxt_st.evt_mask = wdata_in[sbrsf_pkg::EVT_W-1:0];
        end

        pre_sel  = st_ff.bit_rate[sbrsf_pkg::PRE_LSB +: 3];
        rate_sel = st_ff.bit_rate[sbrsf_pkg::RATE_LSB +: 3];
        pre_tick = (st_ff.pre_cnt == pre_sel);
        if (pre_tick) begin
            nxt_st.pre_cnt = 3'h0;
        end else begin
            nxt_st.pre_cnt = st_ff.pre_cnt + 3'h1;
        end

        // Divider only steps on prescaler output.
        div_inc = st_ff.div_cnt + 8'h01;
        if (pre_tick) begin
            nxt_st.div_cnt = div_inc;
        end

        nxt_st.bit_clk  = st_ff.div_cnt[rate_sel];
        // Tick on each bit clock edge, twice per prescale-times-rate period.
        nxt_st.bit_tick = pre_tick && (st_ff.div_cnt[rate_sel] != div_inc[rate_sel]);

        if (wr_rate) begin
            nxt_st.pre_cnt = 3'h0;
            nxt_st.div_cnt = 8'h00;
        end

        fault_armed = st_ff.ctrl_one[sbrsf_pkg::C1_MASTER_SELECT]
                      && st_ff.ctrl_two[sbrsf_pkg::C2_FAULT_DETECT_EN]
                      && !st_ff.ctrl_one[sbrsf_pkg::C1_SELECT_OUT_EN];
        fault_set = fault_armed && !st_ff.ss_n;

        if (rd_status && st_ff.m_fault) begin
            nxt_st.mf_arm = 1'b1;
        end
        mf_clear = wr_ctrl_one && st_ff.mf_arm;
        if (mf_clear) begin
            nxt_st.m_fault = 1'b0;
            nxt_st.mf_arm  = 1'b0;
        end
        if (fault_set) begin
            nxt_st.m_fault = 1'b1;
        end

        // Status read then data read clears.
        if (rd_status && st_ff.rx_full) begin
            nxt_st.rx_arm = 1'b1;
        end
        rx_clear = rd_data && st_ff.rx_arm;
        if (rx_clear) begin
            nxt_st.rx_full = 1'b0;
            nxt_st.rx_arm  = 1'b0;
        end
        if (rx_done_in.valid) begin
            nxt_st.rx_full = 1'b1;
            // Overrun keeps the old byte unless it is read out in this same cycle.
            if (!st_ff.rx_full || rx_clear) begin
                nxt_st.rx_buf = rx_done_in.data;
            end
        end

        // Write needs prior status read with flag set.
        if (rd_status && st_ff.tx_empty) begin
            nxt_st.tx_arm = 1'b1;
        end
        tx_accept = wr_data && st_ff.tx_arm && !st_ff.buf_full;

        buf_after  = st_ff.buf_full;
        byte_after = st_ff.tx_buf;
        if (tx_accept) begin
            buf_after  = 1'b1;
            byte_after = wdata_in;
            nxt_st.tx_arm = 1'b0;
            nxt_st.tx_empty = 1'b0;
        end
        nxt_st.buf_full = buf_after;
        nxt_st.tx_buf   = byte_after;

        if (rx_done_in.valid) begin
            nxt_st.shift_busy = 1'b0;
        end

        // Idle shifter takes the byte next cycle.
        // Queued byte moves at shift end.
        do_load = st_ff.buf_full && (!st_ff.shift_busy || rx_done_in.valid);
        nxt_st.load.valid = do_load;
        nxt_st.load.data  = st_ff.tx_buf;
        if (do_load) begin
            nxt_st.shift_busy = 1'b1;
            nxt_st.buf_full   = tx_accept;
            nxt_st.tx_empty   = !tx_accept;
        end

        // Sticky events, cleared by writing one; a new event wins.
        evt_set = 3'h0;
        evt_set[sbrsf_pkg::EVT_XFER_DONE] = rx_done_in.valid;
        evt_set[sbrsf_pkg::EVT_M_FAULT]   = fault_set && !st_ff.m_fault;
        evt_set[sbrsf_pkg::EVT_TX_LOAD]   = do_load;
        if (wr_evt_sts) begin
            nxt_st.evt_sts = st_ff.evt_sts & ~wdata_in[sbrsf_pkg::EVT_W-1:0];
        end
        nxt_st.evt_sts = nxt_st.evt_sts | evt_set;

        // Status reads zero in unused bits; writes ignored.
        rd_word = 8'h00;
        if (rd_in) begin
            case (addr_in)
                sbrsf_pkg::OFS_BIT_RATE: begin
                    rd_word = st_ff.bit_rate;
                end
                sbrsf_pkg::OFS_STATUS: begin
                    rd_word = status_word(st_ff);
                end
                sbrsf_pkg::OFS_CTRL_ONE: begin
                    rd_word = st_ff.ctrl_one;
                end
                sbrsf_pkg::OFS_CTRL_TWO: begin
                    rd_word = st_ff.ctrl_two;
                end
                sbrsf_pkg::OFS_DATA: begin
                    rd_word = st_ff.rx_buf;
                end
                sbrsf_pkg::OFS_EVT_STS: begin
                    rd_word = {5'h00, st_ff.evt_sts};
                end
                sbrsf_pkg::OFS_EVT_MASK: begin
                    rd_word = {5'h00, st_ff.evt_mask};
                end
                default: begin
                    rd_word = 8'h00;
                end
            endcase
        end
        // Read data stand for one cycle only, then return to zero.
        nxt_st.rdata = rd_word;

        // Synchronous part of reset, held until the release has passed the pipe.
        if (!st_ff.rst_pipe[1]) begin
            nxt_st.ss_pipe    = 3'h7;
            nxt_st.ss_n       = 1'b1;
            nxt_st.bit_rate   = sbrsf_pkg::RST_BIT_RATE;
            nxt_st.ctrl_one   = sbrsf_pkg::RST_CTRL_ONE;
            nxt_st.ctrl_two   = sbrsf_pkg::RST_CTRL_TWO;
            nxt_st.pre_cnt    = 3'h0;
            nxt_st.div_cnt    = 8'h00;
            nxt_st.bit_clk    = 1'b0;
            nxt_st.bit_tick   = 1'b0;
            nxt_st.rx_full    = 1'b0;
            nxt_st.tx_empty   = 1'b1;
            nxt_st.m_fault    = 1'b0;
            nxt_st.rx_arm     = 1'b0;
            nxt_st.tx_arm     = 1'b0;
            nxt_st.mf_arm     = 1'b0;
            nxt_st.buf_full   = 1'b0;
            nxt_st.tx_buf     = 8'h00;
            nxt_st.shift_busy = 1'b0;
            nxt_st.load       = '0;
            nxt_st.rx_buf     = 8'h00;
            nxt_st.evt_sts    = 3'h0;
            nxt_st.evt_mask   = sbrsf_pkg::RST_EVT_MASK;
            nxt_st.rdata      = 8'h00;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // Same values as the synchronous part, so release starts from a known state.
            st_ff.rst_pipe   <= 2'h0;
            st_ff.ss_pipe    <= 3'h7;
            st_ff.ss_n       <= 1'b1;
            st_ff.bit_rate   <= sbrsf_pkg::RST_BIT_RATE;
            st_ff.ctrl_one   <= sbrsf_pkg::RST_CTRL_ONE;
            st_ff.ctrl_two   <= sbrsf_pkg::RST_CTRL_TWO;
            st_ff.pre_cnt    <= 3'h0;
            st_ff.div_cnt    <= 8'h00;
            st_ff.bit_clk    <= 1'b0;
            st_ff.bit_tick   <= 1'b0;
            st_ff.rx_full    <= 1'b0;
            st_ff.tx_empty   <= 1'b1;
            st_ff.m_fault    <= 1'b0;
            st_ff.rx_arm     <= 1'b0;
            st_ff.tx_arm     <= 1'b0;
            st_ff.mf_arm     <= 1'b0;
            st_ff.buf_full   <= 1'b0;
            st_ff.tx_buf     <= 8'h00;
            st_ff.shift_busy <= 1'b0;
            st_ff.load       <= '0;
            st_ff.rx_buf     <= 8'h00;
            st_ff.evt_sts    <= 3'h0;
            st_ff.evt_mask   <= sbrsf_pkg::RST_EVT_MASK;
            st_ff.rdata      <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out    = st_ff.rdata;
    assign load_out     = st_ff.load;
    assign ctrl_one_out = st_ff.ctrl_one;
    assign ctrl_two_out = st_ff.ctrl_two;
    assign bit_clk_out  = st_ff.bit_clk;
    assign bit_tick_out = st_ff.bit_tick;

    assign tx_req       = st_ff.tx_empty && st_ff.ctrl_one[sbrsf_pkg::C1_TX_IRQ_EN];
    assign rx_fault_req = (st_ff.rx_full || st_ff.m_fault)
                          && st_ff.ctrl_one[sbrsf_pkg::C1_RX_FAULT_IRQ_EN];
    // Any unmasked sticky event also requests.
    assign evt_req      = |(st_ff.evt_sts & st_ff.evt_mask);
    assign irq_out      = tx_req || rx_fault_req || evt_req;

endmodule

//--- sbrsf_shifter_model.sv
`timescale 1ns/1ns
module sbrsf_shifter_model (
    // Clock, reset and answer delay.
    input  wire logic                   clk_in,
    input  wire logic                   arst_n_in,
    input  wire logic [7:0]             lat_in,
    // Shifter handshake.
    input  wire sbrsf_pkg::sbrsf_byte_t load_in,
    output sbrsf_pkg::sbrsf_byte_t      rx_done_out
);
    logic [7:0] cnt_ff;
    logic [7:0] byte_ff;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_ff <= 8'h00;
            byte_ff <= 8'h00;
            rx_done_out <= '0;
        end else begin
            rx_done_out.valid <= 1'b0;
            rx_done_out.data <= ~rx_done_out.data;
            if (load_in.valid) begin
                cnt_ff <= lat_in;
                byte_ff <= ~load_in.data;
            end else if (cnt_ff == 8'h01) begin
                rx_done_out.valid <= 1'b1;
                rx_done_out.data <= byte_ff;
                cnt_ff <= 8'h00;
            end else if (cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

//--- sbrsf_core_monitor.sv
`timescale 1ns/1ns
module sbrsf_core_monitor (
    input wire logic                   clk_in,
    input wire logic                   arst_n_in,
    input wire logic [2:0]             addr_in,
    input wire logic [7:0]             wdata_in,
    input wire logic                   wr_in,
    input wire logic                   rd_in,
    input wire logic [7:0]             rdata_out,
    input wire sbrsf_pkg::sbrsf_byte_t rx_done_in,
    input wire sbrsf_pkg::sbrsf_byte_t load_out,
    input wire logic [7:0]             ctrl_one_out,
    input wire logic [7:0]             ctrl_two_out,
    input wire logic                   ss_n_in,
    input wire logic                   bit_clk_out,
    input wire logic                   bit_tick_out,
    input wire logic                   irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire rd_sts = rd_in && (addr_in == sbrsf_pkg::OFS_STATUS);
    wire rd_dat = rd_in && (addr_in == sbrsf_pkg::OFS_DATA);
    wire cfg = ctrl_one_out[4] && ctrl_two_out[4] && !ctrl_one_out[1];
    logic sts_q;
    logic seen_ff;
    logic arm_ff;
    logic gone_ff;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sts_q <= 1'b0;
            seen_ff <= 1'b0;
            arm_ff <= 1'b0;
            gone_ff <= 1'b0;
        end else begin
            sts_q <= rd_sts;
            seen_ff <= rx_done_in.valid || (seen_ff && !rd_dat);
            arm_ff <= !rd_dat && (arm_ff || (sts_q && rdata_out[7]));
            gone_ff <= !rx_done_in.valid && (gone_ff || (rd_dat && arm_ff));
        end
    end

    property p_rd_quiet; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside answer");
    property p_sts_zero; sts_q |-> (rdata_out & 8'h4f) == 8'h00; endproperty
    a_sts_zero: assert property (p_sts_zero) else $error("status spare bits set");
    property p_br_rb;
        (wr_in && addr_in == 3'h0) ##1 !wr_in ##1 (rd_in && addr_in == 3'h0)
        |=> rdata_out == ($past(wdata_in, 3) & 8'h77);
    endproperty
    a_br_rb: assert property (p_br_rb) else $error("bit rate readback wrong");
    property p_load_once; load_out.valid |=> !load_out.valid; endproperty
    a_load_once: assert property (p_load_once) else $error("load longer than one cycle");
    property p_tx_irq; sts_q && rdata_out[5] && ctrl_one_out[5] |-> irq_out; endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt missing");
    property p_rf_irq; sts_q && (rdata_out[7] || rdata_out[4]) && ctrl_one_out[7] |-> irq_out;
    endproperty
    a_rf_irq: assert property (p_rf_irq) else $error("receive or fault interrupt missing");
    property p_fault_set; (!ss_n_in && cfg)[*6] ##1 (rd_sts && !ss_n_in && cfg) |=> rdata_out[4];
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("mode fault not flagged");
    property p_rx_set; sts_q && $past(seen_ff) |-> rdata_out[7]; endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive full not flagged");
    property p_rx_clr; sts_q && $past(gone_ff) && !$past(rx_done_in.valid) |-> !rdata_out[7];
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("receive full not cleared");
endmodule

bind sbrsf_core sbrsf_core_monitor u_mon (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rx_done_in(rx_done_in), .load_out(load_out),
    .ctrl_one_out(ctrl_one_out), .ctrl_two_out(ctrl_two_out), .ss_n_in(ss_n_in),
    .bit_clk_out(bit_clk_out), .bit_tick_out(bit_tick_out), .irq_out(irq_out));

//--- tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    logic clk_in = 1'b0, arst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ss_n_in = 1'b1;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00, lat = 8'h1e, q, rdata_out, ctrl_one_out, ctrl_two_out;
    logic bit_clk_out, bit_tick_out, irq_out;
    sbrsf_pkg::sbrsf_byte_t rx_done, load_out;
    logic [7:0] loads[$];
    int error_cnt = 0, n_checks = 0, cyc = 0, n_ticks = 0;

    always #2 clk_in = ~clk_in;

    sbrsf_core DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .rx_done_in(rx_done), .load_out(load_out), .ctrl_one_out(ctrl_one_out),
        .ctrl_two_out(ctrl_two_out), .ss_n_in(ss_n_in), .bit_clk_out(bit_clk_out),
        .bit_tick_out(bit_tick_out), .irq_out(irq_out));
    sbrsf_shifter_model peer (.clk_in(clk_in), .arst_n_in(arst_n_in), .lat_in(lat),
        .load_in(load_out), .rx_done_out(rx_done));

    always @(posedge clk_in) begin
        if (load_out.valid === 1'b1) loads.push_back(load_out.data);
        if (bit_tick_out === 1'b1) n_ticks++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1 q = rdata_out;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask

    task automatic t_regs;
        logic [7:0] rst [8];
        rst = '{8'h00, 8'h20, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (i != 4) rdchk(3'(i), rst[i]);
        end
        `CHK(irq_out, 1'b0)
        bus(1'b1, 3'h1, 8'hff);
        bus(1'b1, 3'h7, 8'hff);
        rdchk(3'h1, 8'h20);
        rdchk(3'h7, 8'h00);
    endtask

    task automatic t_rate;
        time t0;
        int n0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 3'h0, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
            rdchk(3'h0, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
            @(posedge bit_clk_out);
            t0 = $time;
            n0 = n_ticks;
            @(posedge bit_clk_out);
            `CHK(($time - t0) / 4, (i + 1) * (2 ** (8 - i)))
            `CHK(n_ticks - n0, 2)
        end
    endtask

    task automatic t_tx;
        rdchk(3'h1, 8'h20);
        bus(1'b1, 3'h4, 8'ha5);
        rdchk(3'h1, 8'h20);
        `CHK(loads[0], 8'ha5)
        bus(1'b1, 3'h4, 8'h3c);
        rdchk(3'h1, 8'h00);
        bus(1'b1, 3'h4, 8'h77);
        for (int i = 0; i < 100 && loads.size() < 2; i++) @(posedge clk_in);
        rdchk(3'h1, 8'ha0);
        `CHK(loads[1], 8'h3c)
        repeat (40) @(posedge clk_in);
        rdchk(3'h1, 8'ha0);
        `CHK(loads.size(), 2)
        rdchk(3'h4, 8'h5a);
        rdchk(3'h1, 8'h20);
        bus(1'b1, 3'h4, 8'h01);
        repeat (40) @(posedge clk_in);
        rdchk(3'h4, 8'hfe);
        rdchk(3'h1, 8'ha0);
        rdchk(3'h4, 8'hfe);
        rdchk(3'h1, 8'h20);
    endtask

    task automatic t_irq;
        bus(1'b1, 3'h2, 8'h24);
        `CHK(irq_out, 1'b1)
        rdchk(3'h1, 8'h20);
        bus(1'b1, 3'h2, 8'h04);
        `CHK(irq_out, 1'b0)
        bus(1'b1, 3'h6, 8'h01);
        `CHK(irq_out, 1'b1)
        bus(1'b1, 3'h5, 8'h07);
        `CHK(irq_out, 1'b0)
        rdchk(3'h5, 8'h00);
        bus(1'b1, 3'h6, 8'h00);
    endtask

    task automatic t_fault;
        logic [7:0] c1 [4];
        logic [7:0] c2 [4];
        c1 = '{8'h90, 8'h92, 8'h90, 8'h80};
        c2 = '{8'h10, 8'h10, 8'h00, 8'h10};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 3'h3, c2[i]);
            bus(1'b1, 3'h2, c1[i]);
            `CHK({ctrl_one_out, ctrl_two_out}, {c1[i], c2[i]})
            @(posedge clk_in);
            ss_n_in <= 1'b0;
            repeat (8) @(posedge clk_in);
            rdchk(3'h1, {3'h1, i == 0, 4'h0});
            `CHK(irq_out, i == 0)
            @(posedge clk_in);
            ss_n_in <= 1'b1;
            repeat (6) @(posedge clk_in);
            bus(1'b1, 3'h2, c1[i]);
            rdchk(3'h1, 8'h20);
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_regs();
        t_rate();
        t_tx();
        t_irq();
        t_fault();
        summarize();
    end
endmodule
